// *** shared/pin_combo_pkg.sv ***
package pin_combo_pkg;

    // Clock and timing
    localparam int CLOCK_MHZ = 100;
    localparam int HOLD_STEP_MS = 500;
    localparam int PULSE_STEP_US = 500;
    localparam int HOLD_STEP_CYCLES = HOLD_STEP_MS * 1000 * CLOCK_MHZ;
    localparam int PULSE_STEP_CYCLES = PULSE_STEP_US * CLOCK_MHZ;

    // Register offsets
    localparam logic [7:0] ADDR_LOWER_DRIVE = 8'h25;
    localparam logic [7:0] ADDR_UPPER_DRIVE = 8'h26;
    localparam logic [7:0] ADDR_LOWER_OUT_EN = 8'h27;
    localparam logic [7:0] ADDR_UPPER_OUT_EN = 8'h28;
    localparam logic [7:0] ADDR_LOWER_IN_EN = 8'h29;
    localparam logic [7:0] ADDR_UPPER_IN_EN = 8'h2A;
    localparam logic [7:0] ADDR_SLOT_ONE = 8'h2B;
    localparam logic [7:0] ADDR_SLOT_TWO = 8'h2C;
    localparam logic [7:0] ADDR_SLOT_THREE = 8'h2D;

    // Field layout
    localparam int PIN_COUNT = 11;
    localparam int LOWER_PINS = 6;
    localparam int UPPER_PINS = 5;
    localparam int SLOT_COUNT = 3;
    localparam int CODE_W = 7;
    localparam int LEVEL_BIT = 7;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [10:0] PINS_RESET = 11'h000;
    localparam logic [6:0] NO_EVENT = 7'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_PULSE = 4'b0100,
        ST_REARM = 4'b1000
    } combo_state_e;

    // Hold time in half-second steps; zero means immediate
    function automatic logic [5:0] hold_steps(input logic [3:0] code);
        case (code)
            4'h0: hold_steps = 6'h00;
            4'h1: hold_steps = 6'h02;
            4'h2: hold_steps = 6'h03;
            4'h3: hold_steps = 6'h04;
            4'h4: hold_steps = 6'h05;
            4'h5: hold_steps = 6'h06;
            4'h6: hold_steps = 6'h07;
            4'h7: hold_steps = 6'h08;
            4'h8: hold_steps = 6'h0A;
            4'h9: hold_steps = 6'h0C;
            4'hA: hold_steps = 6'h0E;
            4'hB: hold_steps = 6'h10;
            4'hC: hold_steps = 6'h12;
            4'hD: hold_steps = 6'h14;
            4'hE: hold_steps = 6'h16;
            default: hold_steps = 6'h18;
        endcase
    endfunction

    // Pulse width in 500 us steps: 500 us, 1 ms, 2 ms, 10 ms
    function automatic logic [4:0] pulse_steps(input logic [1:0] code);
        case (code)
            2'h0: pulse_steps = 5'h01;
            2'h1: pulse_steps = 5'h02;
            2'h2: pulse_steps = 5'h04;
            default: pulse_steps = 5'h14;
        endcase
    endfunction

endpackage

// *** core/combo_slot.sv ***
module combo_slot
    import pin_combo_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] slot_config,
    input wire logic config_write,
    input wire logic event_valid,
    input wire logic [pin_combo_pkg::CODE_W-1:0] event_code,
    input wire logic event_press,
    input wire logic event_is_key,
    output logic slot_used,
    output logic slot_met
);
    logic [CODE_W-1:0] code;
    logic level;
    logic hit;

    assign code = slot_config[CODE_W-1:0];
    assign level = slot_config[LEVEL_BIT];
    assign slot_used = code != NO_EVENT;
    assign hit = event_valid && slot_used && event_code == code;

    // A new selection forgets what the old one had seen
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            slot_met <= 1'b0;
        else if (config_write)
            slot_met <= 1'b0;
        else if (hit && event_is_key)
            slot_met <= event_press == level;
        else if (hit)
            slot_met <= level & event_press;
    end

    a_key_level_match: assert property (
        @(posedge clock) disable iff (!rstn)
        hit && event_is_key && !config_write |=> slot_met == $past(event_press == level))
        else $error("key slot level match wrong");

    a_release_never_qualifies: assert property (
        @(posedge clock) disable iff (!rstn)
        hit && !event_is_key && !event_press |=> !slot_met)
        else $error("pin release qualified a slot");
endmodule

// *** core/pin_combo_regs.sv ***
// Operation
// - Upper drive-mode bits pick open drain
// - Lower drive-mode bits pick open drain
// - Lower output-enable bits switch pin drivers
// - Upper output-enable bits switch pin drivers
// - Lower input-enable bits switch input paths
// - Upper input-enable bits switch input paths
// - Three slots: event code plus level
// - Zero code drops a slot
// - All used slots must match together
// - Key level bit picks pressed or released
// - Pin events qualify only on press
// - Every slot decodes level alike
// - Hold duration before reset, zero immediate
// - Reset pulse width from two-bit field
module pin_combo_regs
    import pin_combo_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic event_valid,
    input wire logic [pin_combo_pkg::CODE_W-1:0] event_code,
    input wire logic event_press,
    input wire logic event_is_key,
    input wire logic [3:0] hold_code,
    input wire logic [1:0] pulse_code,
    output logic [pin_combo_pkg::PIN_COUNT-1:0] pin_open_drain,
    output logic [pin_combo_pkg::PIN_COUNT-1:0] pin_output_on,
    output logic [pin_combo_pkg::PIN_COUNT-1:0] pin_input_on,
    output logic combo_met,
    output logic combo_pulse
);

    localparam logic [31:0] HOLD_LAST = 32'(HOLD_STEP_CYCLES - 1);
    localparam logic [31:0] PULSE_LAST = 32'(PULSE_STEP_CYCLES - 1);
    localparam logic [31:0] CYCLE_ZERO = 32'h0000_0000;
    localparam logic [31:0] CYCLE_ONE = 32'h0000_0001;
    localparam logic [5:0] NO_STEPS = 6'h00;
    localparam logic [5:0] ONE_STEP = 6'h01;

    logic [7:0] slot_cfg [SLOT_COUNT];
    logic [SLOT_COUNT-1:0] slot_write;
    logic [SLOT_COUNT-1:0] slot_used;
    logic [SLOT_COUNT-1:0] slot_met;
    logic any_used;
    logic all_met;
    logic condition;
    combo_state_e state;
    combo_state_e next_state;
    logic [31:0] cycle_count;
    logic [5:0] step_count;
    logic [5:0] step_target;
    logic step_done;
    logic last_step;

    function automatic logic [7:0] lower_field(input logic [PIN_COUNT-1:0] pins);
        lower_field = 8'(pins[LOWER_PINS-1:0]);
    endfunction

    function automatic logic [7:0] upper_field(input logic [PIN_COUNT-1:0] pins);
        upper_field = 8'(pins[PIN_COUNT-1:LOWER_PINS]);
    endfunction

    function automatic logic is_slot(input logic [7:0] addr);
        is_slot = addr == ADDR_SLOT_ONE || addr == ADDR_SLOT_TWO || addr == ADDR_SLOT_THREE;
    endfunction

    function automatic logic [1:0] slot_index(input logic [7:0] addr);
        if (addr == ADDR_SLOT_TWO)
            slot_index = 2'h1;
        else if (addr == ADDR_SLOT_THREE)
            slot_index = 2'h2;
        else
            slot_index = 2'h0;
    endfunction

    // Reserved bits are never stored, so they cannot read back
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            pin_open_drain <= PINS_RESET;
        else if (reg_write && reg_addr == ADDR_LOWER_DRIVE)
            pin_open_drain[LOWER_PINS-1:0] <= reg_wdata[LOWER_PINS-1:0];
        else if (reg_write && reg_addr == ADDR_UPPER_DRIVE)
            pin_open_drain[PIN_COUNT-1:LOWER_PINS] <= reg_wdata[UPPER_PINS-1:0];
    end

    a_open_drain_write: assert property (
        @(posedge clock) disable iff (!rstn)
        reg_write && reg_addr == ADDR_UPPER_DRIVE
        |=> pin_open_drain[PIN_COUNT-1:LOWER_PINS] == $past(reg_wdata[UPPER_PINS-1:0]))
        else $error("upper drive mode not stored");

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            pin_output_on <= PINS_RESET;
        else if (reg_write && reg_addr == ADDR_LOWER_OUT_EN)
            pin_output_on[LOWER_PINS-1:0] <= reg_wdata[LOWER_PINS-1:0];
        else if (reg_write && reg_addr == ADDR_UPPER_OUT_EN)
            pin_output_on[PIN_COUNT-1:LOWER_PINS] <= reg_wdata[UPPER_PINS-1:0];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            pin_input_on <= PINS_RESET;
        else if (reg_write && reg_addr == ADDR_LOWER_IN_EN)
            pin_input_on[LOWER_PINS-1:0] <= reg_wdata[LOWER_PINS-1:0];
        else if (reg_write && reg_addr == ADDR_UPPER_IN_EN)
            pin_input_on[PIN_COUNT-1:LOWER_PINS] <= reg_wdata[UPPER_PINS-1:0];
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < SLOT_COUNT; i++)
                slot_cfg[i] <= REG_RESET;
        end
        else if (reg_write && is_slot(reg_addr))
            slot_cfg[slot_index(reg_addr)] <= reg_wdata;
    end

    always_comb
    begin
        slot_write = '0;
        if (reg_write && is_slot(reg_addr))
            slot_write[slot_index(reg_addr)] = 1'b1;
    end

    for (genvar g = 0; g < SLOT_COUNT; g++)
    begin : g_slot
        combo_slot i_slot
        (
            .clock(clock),
            .rstn(rstn),
            .slot_config(slot_cfg[g]),
            .config_write(slot_write[g]),
            .event_valid(event_valid),
            .event_code(event_code),
            .event_press(event_press),
            .event_is_key(event_is_key),
            .slot_used(slot_used[g]),
            .slot_met(slot_met[g])
        );
    end

    // Unused slots pass; with no slot in use nothing can trigger
    assign any_used = |slot_used;
    assign all_met = &(slot_met | ~slot_used);
    assign condition = any_used && all_met;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            combo_met <= 1'b0;
        else
            combo_met <= condition;
    end

    a_combo_follows_slots: assert property (
        @(posedge clock) disable iff (!rstn)
        combo_met == $past(condition))
        else $error("combo flag not all slots");

    a_unused_slots_idle: assert property (
        @(posedge clock) disable iff (!rstn)
        slot_used == '0 |=> !combo_met)
        else $error("combo met with no slot used");

    assign step_done = (state == ST_HOLD && cycle_count == HOLD_LAST) ||
        (state == ST_PULSE && cycle_count == PULSE_LAST);
    assign last_step = step_done && step_count == step_target - ONE_STEP;

    // Rearm waits for release so one held combo gives one pulse
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (condition && hold_steps(hold_code) == NO_STEPS)
                    next_state = ST_PULSE;
                else if (condition)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (!condition)
                    next_state = ST_IDLE;
                else if (last_step)
                    next_state = ST_PULSE;
            ST_PULSE:
                if (last_step)
                    next_state = ST_REARM;
            ST_REARM:
                if (!condition)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Codes are latched on entry so a mid-count change cannot stretch a phase
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            step_target <= NO_STEPS;
        else if (state != ST_HOLD && next_state == ST_HOLD)
            step_target <= hold_steps(hold_code);
        else if (state != ST_PULSE && next_state == ST_PULSE)
            step_target <= 6'(pulse_steps(pulse_code));
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            cycle_count <= CYCLE_ZERO;
        else if (next_state != state || step_done)
            cycle_count <= CYCLE_ZERO;
        else if (state == ST_HOLD || state == ST_PULSE)
            cycle_count <= cycle_count + CYCLE_ONE;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            step_count <= NO_STEPS;
        else if (next_state != state)
            step_count <= NO_STEPS;
        else if (step_done)
            step_count <= step_count + ONE_STEP;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            combo_pulse <= 1'b0;
        else
            combo_pulse <= next_state == ST_PULSE;
    end

    a_immediate_pulse: assert property (
        @(posedge clock) disable iff (!rstn)
        state == ST_IDLE && condition && hold_steps(hold_code) == NO_STEPS |=> combo_pulse)
        else $error("immediate hold gave no pulse");

    a_pulse_not_glitch: assert property (
        @(posedge clock) disable iff (!rstn)
        $rose(combo_pulse) |=> combo_pulse)
        else $error("reset pulse too short");

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= READ_ZERO;
        else if (reg_read)
        begin
            if (reg_addr == ADDR_LOWER_DRIVE)
                reg_rdata <= lower_field(pin_open_drain);
            else if (reg_addr == ADDR_UPPER_DRIVE)
                reg_rdata <= upper_field(pin_open_drain);
            else if (reg_addr == ADDR_LOWER_OUT_EN)
                reg_rdata <= lower_field(pin_output_on);
            else if (reg_addr == ADDR_UPPER_OUT_EN)
                reg_rdata <= upper_field(pin_output_on);
            else if (reg_addr == ADDR_LOWER_IN_EN)
                reg_rdata <= lower_field(pin_input_on);
            else if (reg_addr == ADDR_UPPER_IN_EN)
                reg_rdata <= upper_field(pin_input_on);
            else if (is_slot(reg_addr))
                reg_rdata <= slot_cfg[slot_index(reg_addr)];
            else
                reg_rdata <= READ_ZERO;
        end
    end

    a_reserved_read_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        reg_read && reg_addr == ADDR_UPPER_OUT_EN |=> (reg_rdata >> UPPER_PINS) == READ_ZERO)
        else $error("reserved bits read nonzero");
endmodule

// *** tb/event_source.sv ***
module event_source
(
    input wire logic clock,
    input wire logic fire,
    input wire logic [8:0] ev,
    output logic ev_valid,
    output logic [8:0] ev_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus shows the inverse so a stale code never matches
    always_ff @(posedge clock)
    begin
        ev_valid <= fire;
        ev_bus <= fire ? ev : ~ev;
    end
endmodule

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, rstn = 0, wr = 0, rd = 0, fire = 0, ev_valid, seen, combo_seen;
    logic met_all, pulse_out;
    logic [7:0] cfg = 8'h00, addr = 8'h00, wdata = 8'h00, rdata;
    logic [8:0] ev = 9'h000, ev_bus;
    logic [10:0] open_drain, out_on, in_on;
    // Longer hold codes would exceed the cycle budget; the pulse code does not delay the pulse start
    logic [3:0] hold = 4'h0;
    logic [1:0] pulse = 2'h0;
    int num_errors = 0, tests_run = 0;
    always #5 clock = ~clock;
    event_source i_src (.clock(clock), .fire(fire), .ev(ev), .ev_valid(ev_valid),
        .ev_bus(ev_bus));
    pin_combo_regs i_dut (.clock(clock), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_write(wr), .reg_read(rd), .reg_rdata(rdata), .event_valid(ev_valid),
        .event_code(ev_bus[6:0]), .event_press(ev_bus[7]), .event_is_key(ev_bus[8]),
        .hold_code(hold), .pulse_code(pulse), .pin_open_drain(open_drain),
        .pin_output_on(out_on), .pin_input_on(in_on), .combo_met(met_all),
        .combo_pulse(pulse_out));
    function automatic logic want(logic [7:0] c, logic [8:0] e);
        return c[6:0] != 7'h00 && e[6:0] == c[6:0] && (e[8] ? e[7] == c[7] : e[7] && c[7]);
    endfunction
    function automatic logic [7:0] read_mask(logic [7:0] a);
        if (a == 8'h25 || a == 8'h27 || a == 8'h29)
            return 8'h3F;
        return 8'h1F;
    endfunction
    function automatic logic [10:0] merge(logic [10:0] p, logic [7:0] a, logic [7:0] d,
        logic [7:0] lo);
        if (a == lo)
            return {p[10:6], d[5:0]};
        if (a == 8'(lo + 8'h01))
            return {d[4:0], p[5:0]};
        return p;
    endfunction
    task automatic check(string name, logic [10:0] exp, logic [10:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic write_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        #1 addr = a;
        wdata = d;
        wr = 1;
        @(posedge clock);
        #1 wr = 0;
    endtask
    task automatic read_reg(logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 addr = a;
        rd = 1;
        @(posedge clock);
        #1 rd = 0;
        d = rdata;
    endtask
    task automatic send(logic [8:0] e);
        @(posedge clock);
        #1 ev = e;
        fire = 1;
        @(posedge clock);
        #1 fire = 0;
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        logic [7:0] a, d, got;
        logic [10:0] od, oe, ie;
        void'($urandom(32'h6254));
        od = 11'h000;
        oe = 11'h000;
        ie = 11'h000;
        repeat (8) @(posedge clock);
        #1 rstn = 1;
        for (int i = 0; i < 24; i++)
        begin
            a = 8'(8'h25 + $urandom % 6);
            d = 8'($urandom);
            if (i == 0)
            begin
                a = 8'h26;
                d = 8'hFF;
            end
            write_reg(a, d);
            od = merge(od, a, d, 8'h25);
            oe = merge(oe, a, d, 8'h27);
            ie = merge(ie, a, d, 8'h29);
            read_reg(a, got);
            check("register readback", 11'(d & read_mask(a)), 11'(got));
            check("pin_open_drain", od, open_drain);
            check("pin_output_on", oe, out_on);
            check("pin_input_on", ie, in_on);
        end
        for (int i = 0; i < 32; i++)
        begin
            cfg = 8'($urandom);
            if (i % 4 == 0)
                cfg[6:0] = 7'h00;
            write_reg(8'h2B, cfg);
            read_reg(8'h2B, got);
            check("slot readback", 11'(cfg), 11'(got));
            check("slot_used", 11'(cfg[6:0] != 7'h00), 11'(i_dut.g_slot[0].i_slot.slot_used));
            ev = 9'($urandom);
            if (i % 2 == 1)
                ev[6:0] = cfg[6:0];
            send(ev);
            seen = 0;
            combo_seen = 0;
            repeat (4)
            begin
                @(posedge clock);
                #1 seen = seen | i_dut.g_slot[0].i_slot.slot_met;
                combo_seen = combo_seen | met_all;
            end
            check("slot_met", 11'(want(cfg, ev)), 11'(seen));
            check("combo_met", 11'(want(cfg, ev)), 11'(combo_seen));
        end
        @(posedge clock);
        #1 rstn = 0;
        repeat (2) @(posedge clock);
        #1 rstn = 1;
        @(posedge clock);
        #1 check("pin_open_drain after reset", 11'h000, open_drain);
        check("combo_pulse after reset", 11'h000, 11'(pulse_out));
        write_reg(8'h2B, 8'h85);
        write_reg(8'h2C, 8'h89);
        send(9'h185);
        repeat (3) @(posedge clock);
        #1 check("combo_met one slot", 11'h000, 11'(met_all));
        send(9'h089);
        for (int n = 0; n < 8 && !pulse_out; n++)
        begin
            @(posedge clock);
            #1;
        end
        check("combo_met all slots", 11'h001, 11'(met_all));
        check("combo_pulse", 11'h001, 11'(pulse_out));
        close_out();
    end
endmodule
